// file: rtl/mtpsp_host.sv
module mtpsp_host (
  input  wire logic                          mclk,          // 20 MHz clock
  input  wire logic                          rst,           // sync reset, high
  input  wire logic                          poll_start,    // start status poll
  input  wire mtpsp_pkg::mtpsp_op_type       poll_op,       // program or erase
  input  wire logic [mtpsp_pkg::ADDR_W-1:0]  program_target_address, // polled addr
  input  wire logic [mtpsp_pkg::DATA_W-1:0]  expect_data,   // word being written
  input  wire logic                          use_toggle,    // toggle method
  input  wire logic                          reset_req,     // reset the device
  input  wire logic [mtpsp_pkg::DATA_W-1:0]  dq_in,         // device data bus
  output mtpsp_pkg::mtpsp_pins_type          pins,          // device controls
  output logic                               busy,          // host sequence running
  output logic                               result_valid,  // result pulse
  output mtpsp_pkg::mtpsp_res_type           result_q,      // outcome
  output logic [mtpsp_pkg::ADDR_W-1:0]       bad_addr_q     // failed word address
);

  // ==========================================================================
  // state machine
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_READ   = 3'b001,
    ST_EVAL   = 3'b010,
    ST_RECHK  = 3'b011,
    ST_RST_LO = 3'b100,
    ST_RST_HI = 3'b101
  } mtpsp_state_type;

  mtpsp_state_type                     state_q, state_d;
  logic [mtpsp_pkg::CNT_W-1:0]         cnt_q;
  logic [mtpsp_pkg::CNT_W-1:0]         rst_len_q;
  logic [mtpsp_pkg::ADDR_W-1:0]        addr_q;
  logic [mtpsp_pkg::DATA_W-1:0]        exp_q;
  logic [mtpsp_pkg::DATA_W-1:0]        prev_q;
  mtpsp_pkg::mtpsp_op_type             op_q;
  logic                                tog_q;
  logic                                have_prev_q;
  logic                                recheck_q;
  logic                                rd_start;
  logic                                rd_strobe;
  logic                                rd_done;
  logic [mtpsp_pkg::DATA_W-1:0]        rd_data;
  logic                                reset_n_q;
  logic                                cnt_zero;

  mtpsp_read u_read (
    .mclk   (mclk),
    .rst    (rst),
    .start  (rd_start),
    .dq_in  (dq_in),
    .strobe (rd_strobe),
    .done   (rd_done),
    .data_q (rd_data)
  );

  // ==========================================================================
  // status decode
  wire poll_ok  = rd_data[mtpsp_pkg::POLL_BIT_POS] == exp_q[mtpsp_pkg::POLL_BIT_POS];
  wire tog_diff = rd_data[mtpsp_pkg::TOGGLE_BIT_POS] != prev_q[mtpsp_pkg::TOGGLE_BIT_POS];
  wire tmo      = rd_data[mtpsp_pkg::TIMEOUT_BIT_POS];
  wire still    = tog_q ? tog_diff : !poll_ok;
  wire need_cmp = tog_q && !have_prev_q;
  wire fail_res = (op_q == mtpsp_pkg::MTPSP_OP_ERASE);
  wire [1:0] fail_code = fail_res ? 2'b11 : 2'b10;

  assign cnt_zero = (cnt_q == mtpsp_pkg::CNT_ZERO);
  assign rd_start = (state_q == ST_READ) && !rd_strobe && !rd_done;
  assign busy     = (state_q != ST_IDLE);

  assign pins.ce_n    = !rd_strobe;
  assign pins.oe_n    = !rd_strobe;
  assign pins.addr    = addr_q;
  assign pins.reset_n = reset_n_q;

  // ==========================================================================
  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (reset_req) begin
          state_d = ST_RST_LO;
        end else if (poll_start) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        if (rd_done) begin
          state_d = ST_EVAL;
        end
      end
      ST_EVAL: begin
        if (reset_req) begin
          state_d = ST_RST_LO;
        end else if (need_cmp || still && !tmo) begin
          state_d = ST_READ;
        end else if (still && tmo && !recheck_q) begin
          state_d = ST_READ;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_RECHK: state_d = ST_IDLE;
      ST_RST_LO: begin
        if (cnt_zero) begin
          state_d = ST_RST_HI;
        end
      end
      ST_RST_HI: begin
        if (cnt_zero) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // ==========================================================================
  // registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q      <= ST_IDLE;
      cnt_q        <= mtpsp_pkg::CNT_ZERO;
      rst_len_q    <= mtpsp_pkg::CNT_ZERO;
      addr_q       <= 20'h0_0000;
      exp_q        <= 16'h0000;
      prev_q       <= 16'h0000;
      op_q         <= mtpsp_pkg::MTPSP_OP_PROGRAM;
      tog_q        <= 1'b0;
      have_prev_q  <= 1'b0;
      recheck_q    <= 1'b0;
      reset_n_q    <= 1'b1;
      result_valid <= 1'b0;
      result_q     <= mtpsp_pkg::MTPSP_RES_NONE;
      bad_addr_q   <= 20'h0_0000;
    end else begin
      state_q      <= state_d;
      result_valid <= 1'b0;
      if (state_q == ST_IDLE && state_d == ST_READ) begin
        addr_q      <= program_target_address;
        exp_q       <= expect_data;
        op_q        <= poll_op;
        tog_q       <= use_toggle;
        have_prev_q <= 1'b0;
        recheck_q   <= 1'b0;
      end
      if (state_q == ST_EVAL) begin
        prev_q      <= rd_data;
        have_prev_q <= 1'b1;
        if (still && tmo && !need_cmp) begin
          recheck_q <= 1'b1;
        end
        if (state_d == ST_IDLE) begin
          result_valid <= 1'b1;
          if (still) begin
            result_q <= mtpsp_pkg::mtpsp_res_type'(fail_code);
            if (!fail_res) begin
              bad_addr_q <= addr_q;
            end
          end else begin
            result_q <= mtpsp_pkg::MTPSP_RES_DONE;
          end
        end
      end
      if (state_d == ST_RST_LO && state_q != ST_RST_LO) begin
        reset_n_q <= 1'b0;
        // a poll in progress means an embedded algorithm may be running
        cnt_q <= (state_q == ST_EVAL)
               ? 9'(mtpsp_pkg::ABORT_RESET_CYC - 1)
               : 9'(mtpsp_pkg::IDLE_RESET_CYC - 1);
      end else if (state_q == ST_RST_LO && cnt_zero) begin
        reset_n_q <= 1'b1;
        cnt_q     <= 9'(mtpsp_pkg::RESET_HIGH_CYC - 1);
      end else if (!cnt_zero) begin
        cnt_q <= cnt_q - 9'h001;
      end
      if (state_q == ST_RST_LO) begin
        rst_len_q <= rst_len_q + 9'h001;
      end else begin
        rst_len_q <= mtpsp_pkg::CNT_ZERO;
      end
    end
  end

  // ==========================================================================
  // checks
  sequence s_rst_rise;
    !pins.reset_n ##1 pins.reset_n;
  endsequence

  chk_reset_low_min: assert property (@(posedge mclk) disable iff (rst)
    $fell(pins.reset_n) |-> !pins.reset_n [*8] ##1 !pins.reset_n [*2])
    else $error("reset pulse shorter than idle minimum");
  chk_reset_high_read: assert property (@(posedge mclk) disable iff (rst)
    s_rst_rise |-> !rd_strobe)
    else $error("read started too soon after reset release");
  chk_abort_len: assert property (@(posedge mclk) disable iff (rst)
    $rose(pins.reset_n) && rst_len_q > 9'(mtpsp_pkg::IDLE_RESET_CYC) |->
      rst_len_q == 9'(mtpsp_pkg::ABORT_RESET_CYC))
    else $error("abort reset pulse length wrong");
  chk_poll_addr: assert property (@(posedge mclk) disable iff (rst)
    rd_strobe && $past(rd_strobe) |-> $stable(pins.addr))
    else $error("poll address changed during read");
  chk_timeout_recheck: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_EVAL && still && tmo && !recheck_q |=> state_q == ST_READ)
    else $error("no recheck after timeout flag");
  chk_toggle_pair: assert property (@(posedge mclk) disable iff (rst)
    result_valid && tog_q |-> have_prev_q)
    else $error("toggle result from a single read");
  chk_erase_fail: assert property (@(posedge mclk) disable iff (rst)
    result_valid && op_q == mtpsp_pkg::MTPSP_OP_ERASE |->
      result_q != mtpsp_pkg::MTPSP_RES_WORD_BAD)
    else $error("erase timeout reported as word");
  chk_word_bad: assert property (@(posedge mclk) disable iff (rst)
    result_valid && result_q == mtpsp_pkg::MTPSP_RES_WORD_BAD |->
      bad_addr_q == addr_q)
    else $error("bad word address not recorded");

endmodule : mtpsp_host

// file: rtl/mtpsp_pkg.sv
package mtpsp_pkg;

  // ==========================================================================
  // bus widths
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;

  // ==========================================================================
  // status bit positions
  localparam int unsigned POLL_BIT_POS    = 7;
  localparam int unsigned TOGGLE_BIT_POS  = 6;
  localparam int unsigned TIMEOUT_BIT_POS = 5;

  // ==========================================================================
  // timing
  localparam int unsigned MCLK_NS                    = 50;
  localparam int unsigned ABORT_RESET_PULSE_MIN_US   = 10;
  localparam int unsigned IDLE_RESET_PULSE_MIN_NS    = 500;
  localparam int unsigned RESET_READY_MAX_NS         = 500;
  localparam int unsigned RESET_HIGH_BEFORE_READ_NS  = 50;
  localparam int unsigned READ_STROBE_NS             = 150;
  localparam int unsigned ABORT_RESET_CYC =
    (ABORT_RESET_PULSE_MIN_US * 1000 + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned IDLE_RESET_CYC =
    (IDLE_RESET_PULSE_MIN_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned READY_WAIT_CYC =
    (RESET_READY_MAX_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned RESET_HIGH_CYC =
    (RESET_HIGH_BEFORE_READ_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned READ_CYC =
    (READ_STROBE_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    MTPSP_OP_PROGRAM = 2'b00,
    MTPSP_OP_ERASE   = 2'b01
  } mtpsp_op_type;

  typedef enum logic [1:0] {
    MTPSP_RES_NONE      = 2'b00,
    MTPSP_RES_DONE      = 2'b01,
    MTPSP_RES_WORD_BAD  = 2'b10,
    MTPSP_RES_CHIP_BAD  = 2'b11
  } mtpsp_res_type;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic              reset_n;
  } mtpsp_pins_type;

endpackage : mtpsp_pkg

// file: rtl/mtpsp_read.sv
module mtpsp_read (
  input  wire logic                          mclk,      // system clock
  input  wire logic                          rst,       // sync reset
  input  wire logic                          start,     // begin one read
  input  wire logic [mtpsp_pkg::DATA_W-1:0]  dq_in,     // device data
  output logic                               strobe,    // ce/oe low
  output logic                               done,      // data captured pulse
  output logic [mtpsp_pkg::DATA_W-1:0]       data_q     // captured word
);

  // ==========================================================================
  // fixed-length read strobe, data sampled on the last cycle
  logic [3:0] cnt_q;
  logic       busy_q;
  logic       last;

  assign last   = busy_q && (cnt_q == 4'(mtpsp_pkg::READ_CYC - 1));
  assign strobe = busy_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
      done   <= 1'b0;
      data_q <= 16'h0000;
    end else begin
      done <= last;
      if (last) begin
        busy_q <= 1'b0;
        data_q <= dq_in;
      end else if (start && !busy_q) begin
        busy_q <= 1'b1;
      end
      cnt_q <= busy_q ? cnt_q + 4'h1 : 4'h0;
    end
  end

endmodule : mtpsp_read

// file: test/mtpsp_dev_model.sv
module mtpsp_dev_model (
  input  wire mtpsp_pkg::mtpsp_pins_type pins,   // host controls
  input  wire logic                      arm,    // new operation begins
  input  wire logic [16:0]               n_busy, // busy reads before the end
  input  wire logic [1:0]                mode,   // 0 ok, 1 timeout, 2 timeout then ok
  input  wire logic [15:0]               word,   // word being written
  output logic [15:0]                    dq      // data to host
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        busy_q = 1'b0;
  logic        tog    = 1'b0;
  logic        tflag  = 1'b0;
  logic [16:0] reads  = 17'h0_0000;
  logic [15:0] cur    = 16'h0000;
  time         t_low  = 0;
  wire         sel    = !pins.ce_n && !pins.oe_n;

  // ==========================================================================
  // operation state
  always @(posedge arm) begin
    busy_q = 1'b1;
    reads  = 17'h0_0000;
    tflag  = 1'b0;
  end
  always @(negedge pins.reset_n) t_low = $time;
  // a short pulse leaves a running operation alone; readable at once when idle
  always @(posedge pins.reset_n) begin
    if ($time - t_low >= 10000) begin
      busy_q = 1'b0;
    end
  end
  always @(posedge sel) begin
    if (busy_q) begin
      reads = reads + 17'h0_0001;
      tog   = ~tog;
      if (mode != 2'h1 && reads > n_busy + {16'h0000, mode == 2'h2}) begin
        busy_q = 1'b0;
      end else if (mode != 2'h0 && reads > n_busy) begin
        tflag = 1'b1;
      end
    end
    cur = busy_q ? {word[15:8], ~word[7], tog, tflag, word[4:0]} : word;
  end
  // released bus shows the inverse of the last word
  assign dq = sel ? cur : ~cur;
endmodule : mtpsp_dev_model

// file: test/mtpsp_host_tb.sv
module mtpsp_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                      mclk       = 1'b0;
  logic                      rst        = 1'b1;
  logic                      poll_start = 1'b0;
  mtpsp_pkg::mtpsp_op_type   poll_op    = mtpsp_pkg::MTPSP_OP_PROGRAM;
  logic [19:0]               va         = 20'h0_0000;
  logic [15:0]               exp_word   = 16'h0000;
  logic                      use_toggle = 1'b0;
  logic                      reset_req  = 1'b0;
  logic                      arm        = 1'b0;
  logic [16:0]               n_busy     = 17'h0_0000;
  logic [1:0]                mode       = 2'h0;
  logic [15:0]               dq;
  mtpsp_pkg::mtpsp_pins_type pins;
  logic                      busy;
  logic                      result_valid;
  mtpsp_pkg::mtpsp_res_type  result_q;
  logic [19:0]               bad_addr_q;
  int                        n_errors    = 0;
  int                        checks_done = 0;
  int                        n_rd        = 0;
  time                       t_rise      = 0;

  always #25 mclk = ~mclk;

  mtpsp_host uut (.mclk(mclk), .rst(rst), .poll_start(poll_start), .poll_op(poll_op),
    .program_target_address(va), .expect_data(exp_word), .use_toggle(use_toggle),
    .reset_req(reset_req), .dq_in(dq), .pins(pins), .busy(busy),
    .result_valid(result_valid), .result_q(result_q), .bad_addr_q(bad_addr_q));
  mtpsp_dev_model dev (.pins(pins), .arm(arm), .n_busy(n_busy), .mode(mode),
    .word(exp_word), .dq(dq));

  // ==========================================================================
  // checking and ending
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic expired(input int i, input int n);
    if (i >= n) begin
      n_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      wrap_up();
    end
  endtask : expired

  always @(posedge pins.reset_n) t_rise = $time;
  always @(negedge pins.oe_n) begin
    n_rd++;
    if (busy === 1'b1) check(32'(pins.addr), 32'(va));
    check(32'($time - t_rise >= 50), 32'h1);
  end

  function automatic mtpsp_pkg::mtpsp_res_type want_res(input mtpsp_pkg::mtpsp_op_type op,
                                                         input logic [1:0] md);
    if (md != 2'h1) return mtpsp_pkg::MTPSP_RES_DONE;
    if (op == mtpsp_pkg::MTPSP_OP_ERASE) return mtpsp_pkg::MTPSP_RES_CHIP_BAD;
    return mtpsp_pkg::MTPSP_RES_WORD_BAD;
  endfunction : want_res

  // ==========================================================================
  // stimulus
  task automatic launch(input mtpsp_pkg::mtpsp_op_type op, input logic tm, input int nb,
                        input logic [1:0] md);
    @(posedge mclk);
    #1;
    poll_op    = op;
    use_toggle = tm;
    n_busy     = 17'(nb);
    mode       = md;
    va         = 20'($urandom);
    exp_word   = (op == mtpsp_pkg::MTPSP_OP_ERASE) ? 16'hffff : 16'($urandom);
    n_rd       = 0;
    arm        = 1'b1;
    poll_start = 1'b1;
    @(posedge mclk);
    #1;
    poll_start = 1'b0;
    arm        = 1'b0;
  endtask : launch

  task automatic poll(input mtpsp_pkg::mtpsp_op_type op, input logic tm, input int nb,
                      input logic [1:0] md);
    int i;
    launch(op, tm, nb, md);
    for (i = 0; i < 5000 && result_valid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    expired(i, 5000);
    check(32'(result_q), 32'(want_res(op, md)));
    if (md == 2'h1 && op == mtpsp_pkg::MTPSP_OP_PROGRAM) check(32'(bad_addr_q), 32'(va));
    if (md != 2'h0) check(32'(n_rd), 32'(nb + 2));
    if (tm) check(32'(n_rd >= 2), 32'h1);
    $display("poll test done: op %0d toggle %0d mode %0d", op, tm, md);
  endtask : poll

  task automatic reset_dev(input logic mid);
    int  i;
    time t0;
    if (mid) launch(mtpsp_pkg::MTPSP_OP_PROGRAM, 1'b0, 100000, 2'h0);
    repeat (12) @(posedge mclk);
    #1;
    reset_req = 1'b1;
    for (i = 0; i < 300 && pins.reset_n !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    expired(i, 300);
    reset_req = 1'b0;
    t0 = $time;
    for (i = 0; i < 400 && pins.reset_n !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    expired(i, 400);
    check(32'($time - t0 >= (mid ? 10000 : 500)), 32'h1);
    check(32'(dev.busy_q), 32'h0);
    for (i = 0; i < 20 && busy !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    expired(i, 20);
    $display("reset test done: mid %0d", mid);
  endtask : reset_dev

  initial begin
    int         i;
    logic       tm;
    logic [1:0] md;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    void'($urandom(3));
    poll(mtpsp_pkg::MTPSP_OP_PROGRAM, 1'b0, 0, 2'h0);
    poll(mtpsp_pkg::MTPSP_OP_PROGRAM, 1'b1, 0, 2'h0);
    poll(mtpsp_pkg::MTPSP_OP_PROGRAM, 1'b0, 3, 2'h1);
    poll(mtpsp_pkg::MTPSP_OP_PROGRAM, 1'b1, 3, 2'h1);
    poll(mtpsp_pkg::MTPSP_OP_ERASE, 1'b0, 2, 2'h1);
    poll(mtpsp_pkg::MTPSP_OP_ERASE, 1'b1, 2, 2'h1);
    poll(mtpsp_pkg::MTPSP_OP_PROGRAM, 1'b0, 2, 2'h2);
    reset_dev(1'b0);
    reset_dev(1'b1);
    poll(mtpsp_pkg::MTPSP_OP_PROGRAM, 1'b0, 1, 2'h0);
    for (i = 0; i < 24; i++) begin
      tm = 1'($urandom);
      md = 2'($urandom_range(0, tm ? 1 : 2));
      poll(mtpsp_pkg::mtpsp_op_type'($urandom_range(0, 1)), tm, $urandom_range(1, 6), md);
    end
    wrap_up();
  end
endmodule : mtpsp_host_tb
